// ===== core/serial_bridge_pkg.sv
// shared constants and types of the serial packetizing port
package serial_bridge_pkg;

	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_SEC = 1000;
	localparam int BUF_BYTES = 1400;
	localparam int RTS_MARGIN = 16;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT7 = 4'h6;

	typedef enum logic [2:0] {
		BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600,
		BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
	} baud_type;
	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_type;
	typedef enum logic [1:0] {DTR_HIGH, DTR_LOW, DTR_SESSION} dtr_type;
	typedef enum logic [1:0] {DSR_NONE, DSR_ACCEPT, DSR_OPENCLOSE} dsr_type;
	typedef enum logic [1:0] {HOST_SERVER, HOST_CLIENT, HOST_BOTH} host_type;

	typedef struct packed {
		baud_type baud;
		logic dataBits8;
		parity_type parity;
		logic stop2;
		logic flowHw;
		dtr_type dtr;
		dsr_type dsr;
		logic [15:0] gapMs;
		logic [15:0] idleSec;
		host_type host;
	} cfg_type;

	localparam cfg_type CFG_DEFAULT = '{baud: BAUD_9600, dataBits8: 1'b1,
		parity: PAR_NONE, stop2: 1'b0, flowHw: 1'b0, dtr: DTR_HIGH,
		dsr: DSR_NONE, gapMs: 16'h000b, idleSec: 16'h0000,
		host: HOST_SERVER};

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} pkt_type;

	typedef struct packed {
		logic connect;
		logic close;
		logic acceptOk;
	} sess_type;

	// clock cycles per bit at each line rate
	function automatic logic [16:0] bitCycles(baud_type b);
		case (b)
			BAUD_1200: bitCycles = 17'(CLK_HZ / 1200);
			BAUD_2400: bitCycles = 17'(CLK_HZ / 2400);
			BAUD_4800: bitCycles = 17'(CLK_HZ / 4800);
			BAUD_9600: bitCycles = 17'(CLK_HZ / 9600);
			BAUD_19200: bitCycles = 17'(CLK_HZ / 19200);
			BAUD_38400: bitCycles = 17'(CLK_HZ / 38400);
			BAUD_57600: bitCycles = 17'(CLK_HZ / 57600);
			default: bitCycles = 17'(CLK_HZ / 115200);
		endcase
	endfunction : bitCycles

endpackage : serial_bridge_pkg

// ===== core/char_receiver.sv
// asynchronous character receiver with configurable format
`timescale 1ns/1ps
module char_receiver (
	input wire logic core_clk, // system clock
	input wire logic reset, // synchronous reset, active high
	input wire logic rxd, // synchronised serial input
	input wire logic [16:0] bitLen, // cycles per bit
	input wire logic dataBits8, // eight data bits when high
	input wire serial_bridge_pkg::parity_type parity, // parity choice
	output logic charValid, // one-cycle pulse, good character
	output logic [7:0] charData // received character
);
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
	} rx_state_type;

	rx_state_type state, next_state;
	logic [16:0] cnt, next_cnt;
	logic [3:0] idx, next_idx;
	logic [7:0] shift, next_shift;
	logic par, next_par;
	logic next_charValid;
	logic [7:0] next_charData;
	logic [3:0] lastIdx;

	assign lastIdx = dataBits8 ? serial_bridge_pkg::LAST_BIT8 :
		serial_bridge_pkg::LAST_BIT7;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_idx = idx;
		next_shift = shift;
		next_par = par;
		next_charValid = 1'b0;
		next_charData = charData;
		if (cnt != 17'h0)
			next_cnt = cnt - 17'h1;
		case (state)
			RX_IDLE: if (!rxd) begin
				// sample the middle of each bit
				next_state = RX_START;
				next_cnt = bitLen >> 1;
			end
			RX_START: if (cnt == 17'h0) begin
				if (rxd)
					next_state = RX_IDLE;
				else begin
					next_state = RX_DATA;
					next_cnt = bitLen - 17'h1;
					next_idx = 4'h0;
					next_par = 1'b0;
				end
			end
			RX_DATA: if (cnt == 17'h0) begin
				next_shift = {rxd, shift[7:1]};
				next_par = par ^ rxd;
				next_idx = idx + 4'h1;
				next_cnt = bitLen - 17'h1;
				if (idx == lastIdx)
					next_state = (parity == serial_bridge_pkg::PAR_NONE) ?
						RX_STOP : RX_PAR;
			end
			RX_PAR: if (cnt == 17'h0) begin
				next_par = par ^ rxd;
				next_cnt = bitLen - 17'h1;
				next_state = RX_STOP;
			end
			RX_STOP: if (cnt == 17'h0) begin
				// bad stop or parity drops the character
				next_state = RX_IDLE;
				next_charValid = rxd &&
					(parity == serial_bridge_pkg::PAR_NONE ||
					par == (parity == serial_bridge_pkg::PAR_ODD));
				next_charData = dataBits8 ? shift : {1'b0, shift[7:1]};
			end
			default: next_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= RX_IDLE;
			cnt <= 17'h0;
			idx <= 4'h0;
			shift <= 8'h00;
			par <= 1'b0;
			charValid <= 1'b0;
			charData <= 8'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			idx <= next_idx;
			shift <= next_shift;
			par <= next_par;
			charValid <= next_charValid;
			charData <= next_charData;
		end
	end

endmodule : char_receiver

// ===== core/serial_packet_port.sv
// serial port side of the serial-to-network bridge
`timescale 1ns/1ps
// Overview of operation
// [R01] line rates 1200 to 115200 bit/s selected by configuration
// [R02] seven or eight data bits, none/even/odd parity, one or two stops
// [R03] factory defaults give 9600 bit/s, eight bits, no parity, one stop
// [R04] seven bits, no parity, one stop runs with two stops
// [R05] eight bits with parity and two stops runs with one stop
// [R06] flow control none by default, else RTS/CTS hardware only
// [R07] DTR is only driven, DSR is only sampled
// [R08] DTR high, low, or high while the session is established
// [R09] accept-by-high DSR lets incoming sessions in only while DSR high
// [R10] open-close DSR: high requests a session, low closes it
// [R11] buffered characters leave only on full buffer or gap timeout
// [R12] receive buffer holds 1400 bytes, largest packet released
// [R13] gap limit is given in ms and exceeds 10 ms
// [R14] gap limit should exceed one character time
// [R15] sender keeps gaps under the limit and groups within buffer size
// [R16] combined mode listens, and serial data requests a session
// [R17] combined mode accepts incoming sessions while none is established
// [R18] nonzero inactivity limit without traffic closes the session
// [R19] failed session request discards buffered data
// [R20] session disconnect discards buffered data
// [R21] gap timer restarts per character, idles while buffer empty
// [R22] connect and close requested, established indication received
module serial_packet_port #(
	parameter int MS_CYCLES = serial_bridge_pkg::MS_CYCLES
) (
	input wire logic core_clk, // system clock, 100 MHz
	input wire logic reset, // synchronous reset, active high
	input wire serial_bridge_pkg::cfg_type cfgIn, // new configuration
	input wire logic cfgLoad, // pulse: take cfgIn
	input wire logic factoryDefault, // pulse: restore defaults
	input wire logic serRxd, // serial receive pin
	output logic serTxd, // serial transmit pin
	output logic rtsOut, // high: ready to take characters
	input wire logic serCts, // high: partner ready to take
	output logic dtrOut, // data terminal ready pin
	input wire logic dsrIn, // data set ready pin
	input wire logic txValid, // network byte for the line
	input wire logic [7:0] txData, // that byte
	output logic txReady, // transmitter takes the byte
	output serial_bridge_pkg::pkt_type pkt, // packet byte stream
	input wire logic pktReady, // network takes packet byte
	output serial_bridge_pkg::sess_type sess, // session requests
	input wire logic established, // session open, level
	input wire logic connFail // pulse: session request failed
);
	typedef enum logic [1:0] {S_IDLE, S_CONNECT, S_OPEN} sess_state_type;

	serial_bridge_pkg::cfg_type cfg, next_cfg;
	logic [1:0] rxSync, ctsSync, dsrSync;
	logic effStop2;
	logic [16:0] bitLen;
	logic charValid;
	logic [7:0] charData;

	// ==================================================
	// configuration and effective format
	always_comb begin
		next_cfg = cfg;
		if (factoryDefault)
			next_cfg = serial_bridge_pkg::CFG_DEFAULT; // [R03]
		else if (cfgLoad)
			next_cfg = cfgIn; // [R01] [R02] [R06]
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			cfg <= serial_bridge_pkg::CFG_DEFAULT; // [R03] [R06]
		else
			cfg <= next_cfg;
	end

	always_comb begin
		effStop2 = cfg.stop2;
		if (!cfg.dataBits8 && cfg.parity == serial_bridge_pkg::PAR_NONE)
			effStop2 = 1'b1; // [R04]
		if (cfg.dataBits8 && cfg.parity != serial_bridge_pkg::PAR_NONE)
			effStop2 = 1'b0; // [R05]
	end

	assign bitLen = serial_bridge_pkg::bitCycles(cfg.baud); // [R01]

	// ==================================================
	// pin synchronisers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rxSync <= 2'h3;
			ctsSync <= 2'h0;
			dsrSync <= 2'h0;
		end else begin
			rxSync <= {rxSync[0], serRxd};
			ctsSync <= {ctsSync[0], serCts};
			dsrSync <= {dsrSync[0], dsrIn}; // [R07]
		end
	end

	char_receiver u_char_receiver (
		.core_clk(core_clk),
		.reset(reset),
		.rxd(rxSync[1]),
		.bitLen(bitLen),
		.dataBits8(cfg.dataBits8),
		.parity(cfg.parity),
		.charValid(charValid),
		.charData(charData)
	); // [R02]

	// ==================================================
	// transmitter
	logic [11:0] txShift, next_txShift, frame;
	logic [3:0] txLeft, next_txLeft, frameLen;
	logic [16:0] txCnt, next_txCnt;
	logic next_serTxd, next_txReady, ctsOk, txStart;

	// frame laid out LSB first: start, data, parity, stops
	function automatic logic [15:0] buildFrame(logic [7:0] d,
		serial_bridge_pkg::cfg_type c, logic two);
		logic [11:0] f;
		logic [3:0] n;
		f = 12'hfff;
		f[0] = 1'b0;
		n = c.dataBits8 ? 4'h8 : 4'h7;
		for (int i = 0; i < 8; i++)
			if (i < int'(n))
				f[1 + i] = d[i];
		if (c.parity != serial_bridge_pkg::PAR_NONE) begin
			f[4'h1 + n] = ^(c.dataBits8 ? d : {1'b0, d[6:0]}) ^
				(c.parity == serial_bridge_pkg::PAR_ODD);
			n = n + 4'h1;
		end
		buildFrame = {n + (two ? 4'h3 : 4'h2), f};
	endfunction : buildFrame

	assign {frameLen, frame} = buildFrame(txData, cfg, effStop2); // [R02]
	assign ctsOk = !cfg.flowHw || ctsSync[1]; // [R06]
	assign txStart = txValid && txReady;

	always_comb begin
		next_txShift = txShift;
		next_txLeft = txLeft;
		next_txCnt = txCnt;
		if (txStart) begin
			next_txShift = frame;
			next_txLeft = frameLen;
			next_txCnt = bitLen - 17'h1;
		end else if (txLeft != 4'h0) begin
			if (txCnt == 17'h0) begin
				next_txShift = {1'b1, txShift[11:1]};
				next_txLeft = txLeft - 4'h1;
				next_txCnt = bitLen - 17'h1;
			end else
				next_txCnt = txCnt - 17'h1;
		end
		next_serTxd = (next_txLeft != 4'h0) ? next_txShift[0] : 1'b1;
		next_txReady = next_txLeft == 4'h0 && ctsOk; // [R06]
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			txShift <= 12'hfff;
			txLeft <= 4'h0;
			txCnt <= 17'h0;
			serTxd <= 1'b1;
			txReady <= 1'b0;
		end else begin
			txShift <= next_txShift;
			txLeft <= next_txLeft;
			txCnt <= next_txCnt;
			serTxd <= next_serTxd;
			txReady <= next_txReady;
		end
	end

	// ==================================================
	// timers: millisecond tick, gap and inactivity
	logic [16:0] msCnt, next_msCnt;
	logic [9:0] secCnt, next_secCnt;
	logic [15:0] gapCnt, next_gapCnt, idleCnt, next_idleCnt;
	logic msTick, secTick;
	logic [10:0] count, next_count;
	sess_state_type state, next_state;

	assign msTick = msCnt == 17'(MS_CYCLES - 1);
	assign secTick = msTick && secCnt == 10'(serial_bridge_pkg::MS_PER_SEC - 1);

	always_comb begin
		next_msCnt = msTick ? 17'h0 : msCnt + 17'h1;
		next_secCnt = secCnt;
		// second counted from the last activity, not free running
		if (charValid || txStart || state != S_OPEN)
			next_secCnt = 10'h0; // [R18]
		else if (msTick)
			next_secCnt = secTick ? 10'h0 : secCnt + 10'h1;
		next_gapCnt = gapCnt;
		if (charValid || count == 11'h0)
			next_gapCnt = 16'h0; // [R21]
		else if (msTick && gapCnt < cfg.gapMs)
			next_gapCnt = gapCnt + 16'h1; // [R11]
		next_idleCnt = idleCnt;
		if (charValid || txStart || state != S_OPEN)
			next_idleCnt = 16'h0; // [R18]
		else if (secTick && idleCnt != 16'hffff)
			next_idleCnt = idleCnt + 16'h1;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			msCnt <= 17'h0;
			secCnt <= 10'h0;
			gapCnt <= 16'h0;
			idleCnt <= 16'h0;
		end else begin
			msCnt <= next_msCnt;
			secCnt <= next_secCnt;
			gapCnt <= next_gapCnt;
			idleCnt <= next_idleCnt;
		end
	end

	// ==================================================
	// session state and line status
	logic clientType, serverType, dsrOC, wantClose, flush, drainGo;
	logic next_dtrOut, next_rtsOut;
	serial_bridge_pkg::sess_type next_sess;

	assign clientType = cfg.host != serial_bridge_pkg::HOST_SERVER;
	assign serverType = cfg.host != serial_bridge_pkg::HOST_CLIENT;
	assign dsrOC = clientType && cfg.dsr == serial_bridge_pkg::DSR_OPENCLOSE;
	assign wantClose = (cfg.idleSec != 16'h0 && idleCnt >= cfg.idleSec) ||
		(dsrOC && !dsrSync[1]); // [R10] [R18]

	always_comb begin
		next_state = state;
		flush = 1'b0;
		case (state)
			S_IDLE: if (established)
				next_state = S_OPEN; // [R17]
			else if (dsrOC ? dsrSync[1] : (clientType && count != 11'h0))
				next_state = S_CONNECT; // [R10] [R16]
			S_CONNECT: if (established)
				next_state = S_OPEN;
			else if (connFail) begin
				next_state = S_IDLE;
				flush = 1'b1; // [R19]
			end
			S_OPEN: if (!established) begin
				next_state = S_IDLE;
				flush = 1'b1; // [R20]
			end
			default: next_state = S_IDLE;
		endcase
		next_sess.connect = next_state == S_CONNECT; // [R22]
		next_sess.close = next_state == S_OPEN && wantClose; // [R18] [R22]
		next_sess.acceptOk = serverType && next_state == S_IDLE &&
			(cfg.dsr != serial_bridge_pkg::DSR_ACCEPT || dsrSync[1]); // [R09]
		case (cfg.dtr)
			serial_bridge_pkg::DTR_HIGH: next_dtrOut = 1'b1;
			serial_bridge_pkg::DTR_LOW: next_dtrOut = 1'b0;
			default: next_dtrOut = established; // [R08]
		endcase
		next_rtsOut = !cfg.flowHw ||
			count < 11'(serial_bridge_pkg::BUF_BYTES -
			serial_bridge_pkg::RTS_MARGIN); // [R06]
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= S_IDLE; // [R16]
			sess <= '0;
			dtrOut <= 1'b1;
			rtsOut <= 1'b1;
		end else begin
			state <= next_state;
			sess <= next_sess;
			dtrOut <= next_dtrOut; // [R07]
			rtsOut <= next_rtsOut;
		end
	end

	// ==================================================
	// receive buffer and packet release
	logic [7:0] mem [serial_bridge_pkg::BUF_BYTES];
	logic [10:0] wrIdx, next_wrIdx, rdIdx, next_rdIdx;
	logic [10:0] drainLeft, next_drainLeft;
	logic bufFull, store, load;
	serial_bridge_pkg::pkt_type next_pkt;

	assign bufFull = count == 11'(serial_bridge_pkg::BUF_BYTES); // [R12]
	// server mode without a session drops serial data
	assign store = charValid && !bufFull && !flush &&
		(clientType || state == S_OPEN);
	assign drainGo = established && state == S_OPEN && drainLeft == 11'h0 &&
		count != 11'h0 && (bufFull || gapCnt >= cfg.gapMs); // [R11]
	assign load = drainLeft != 11'h0 && (!pkt.valid || pktReady);

	function automatic logic [10:0] wrapInc(logic [10:0] p);
		wrapInc = (p == 11'(serial_bridge_pkg::BUF_BYTES - 1)) ?
			11'h0 : p + 11'h1;
	endfunction : wrapInc

	always_comb begin
		next_wrIdx = store ? wrapInc(wrIdx) : wrIdx;
		next_rdIdx = load ? wrapInc(rdIdx) : rdIdx;
		next_count = count + (store ? 11'h1 : 11'h0) -
			(load ? 11'h1 : 11'h0);
		next_drainLeft = drainGo ? count : drainLeft - (load ? 11'h1 : 11'h0);
		next_pkt = pkt;
		if (load) begin
			next_pkt.valid = 1'b1;
			next_pkt.data = mem[rdIdx];
			next_pkt.last = drainLeft == 11'h1;
		end else if (pktReady)
			next_pkt.valid = 1'b0;
		if (flush) begin
			next_rdIdx = wrIdx; // [R19] [R20]
			next_count = 11'h0;
			next_drainLeft = 11'h0;
			next_pkt.valid = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (store)
			mem[wrIdx] <= charData; // [R12]
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wrIdx <= 11'h0;
			rdIdx <= 11'h0;
			count <= 11'h0;
			drainLeft <= 11'h0;
			pkt <= '0;
		end else begin
			wrIdx <= next_wrIdx;
			rdIdx <= next_rdIdx;
			count <= next_count;
			drainLeft <= next_drainLeft;
			pkt <= next_pkt;
		end
	end

	// ==================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence failSeq;
		state == S_CONNECT && !established ##0 connFail;
	endsequence
	sequence dropSeq;
		state == S_OPEN ##0 !established;
	endsequence

	AST_DEFAULT_FMT: assert property (factoryDefault |=> // [R03]
		cfg.baud == serial_bridge_pkg::BAUD_9600 && cfg.dataBits8 &&
		cfg.parity == serial_bridge_pkg::PAR_NONE && !effStop2)
		else $error("defaults not restored");
	AST_SEVEN_TWO: assert property (!cfg.dataBits8 && // [R04]
		cfg.parity == serial_bridge_pkg::PAR_NONE |->
		effStop2 && frameLen == 4'ha)
		else $error("seven bit frame lacks two stops");
	AST_EIGHT_PAR: assert property (cfg.dataBits8 && // [R05]
		cfg.parity != serial_bridge_pkg::PAR_NONE |->
		!effStop2 && frameLen == 4'hb)
		else $error("parity frame kept two stops");
	AST_DTR_SESSION: assert property ( // [R08]
		cfg.dtr == serial_bridge_pkg::DTR_SESSION && !cfgLoad &&
		!factoryDefault |=> dtrOut == $past(established))
		else $error("dtr does not follow session");
	AST_ACCEPT_DSR: assert property ( // [R09]
		sess.acceptOk && cfg.dsr == serial_bridge_pkg::DSR_ACCEPT &&
		$stable(cfg) |-> $past(dsrSync[1]))
		else $error("accept allowed with dsr low");
	AST_HOLD_RELEASE: assert property ($rose(drainLeft != 11'h0) |-> // [R11]
		$past(established) && ($past(bufFull) ||
		$past(gapCnt) >= $past(cfg.gapMs)))
		else $error("data released early");
	AST_BUF_LIMIT: assert property ( // [R12]
		count <= 11'(serial_bridge_pkg::BUF_BYTES))
		else $error("buffer overfilled");
	AST_FLUSH_FAIL: assert property (failSeq |=> count == 11'h0 && // [R19]
		!pkt.valid ##1 drainLeft == 11'h0)
		else $error("data kept after failed request");
	AST_FLUSH_DROP: assert property (dropSeq |=> count == 11'h0 && // [R20]
		state == S_IDLE)
		else $error("data kept after disconnect");
	AST_GAP_IDLE: assert property (count == 11'h0 |=> gapCnt == 16'h0) // [R21]
		else $error("gap timer runs on empty buffer");
	AST_PKT_HOLD: assert property (pkt.valid && !pktReady && !flush |=> // [R11]
		pkt.valid && $stable(pkt.data))
		else $error("packet byte changed while stalled");

endmodule : serial_packet_port

// ===== tb/serial_device_model.sv
// serial device model attached to the serial port pins
`timescale 1ns/1ps
module serial_device_model (
	input wire logic core_clk, // system clock
	input wire logic lineIn, // port transmit pin
	output logic lineOut, // line into the port receiver
	output logic ctsOut // high: model takes characters
);
	int bitLen = 868;
	logic [8:0] heard;
	initial begin
		lineOut = 1'b1;
		ctsOut = 1'b1;
	end
	// 8N1 character, lsb first, no gap after the stop bit
	task automatic sendChar(input logic [7:0] d);
		@(negedge core_clk);
		lineOut = 1'b0;
		repeat (bitLen) @(negedge core_clk);
		for (int i = 0; i < 8; i++) begin
			lineOut = d[i];
			repeat (bitLen) @(negedge core_clk);
		end
		lineOut = 1'b1;
		repeat (bitLen) @(negedge core_clk);
	endtask : sendChar
	// flow control level offered to the port
	task automatic setCts(input logic v);
		ctsOut = v;
	endtask : setCts
	// nine mid-bit samples after each start edge
	always begin
		@(negedge lineIn);
		repeat (bitLen / 2) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (bitLen) @(posedge core_clk);
			heard[i] = lineIn;
		end
	end
endmodule : serial_device_model

// ===== tb/serial_packet_port_tb_top.sv
// testbench of the serial packetizing port
`timescale 1ns/1ps
module serial_packet_port_tb_top;
	localparam int MS_TB = 5;
	localparam int BIT = serial_bridge_pkg::CLK_HZ / 115200;
	logic core_clk, reset, cfgLoad, factoryDefault, serRxd, serTxd;
	logic rtsOut, serCts, dtrOut, dsrIn, txValid, txReady;
	logic pktReady, established, connFail;
	logic [7:0] txData;
	serial_bridge_pkg::cfg_type cfgIn, c;
	serial_bridge_pkg::pkt_type pkt;
	serial_bridge_pkg::sess_type sess;
	int errCount = 0;
	int checksDone = 0;
	int nb;
	serial_packet_port #(.MS_CYCLES(MS_TB)) u_serial_packet_port (
		.core_clk(core_clk), .reset(reset), .cfgIn(cfgIn),
		.cfgLoad(cfgLoad), .factoryDefault(factoryDefault),
		.serRxd(serRxd), .serTxd(serTxd), .rtsOut(rtsOut),
		.serCts(serCts), .dtrOut(dtrOut), .dsrIn(dsrIn),
		.txValid(txValid), .txData(txData), .txReady(txReady),
		.pkt(pkt), .pktReady(pktReady), .sess(sess),
		.established(established), .connFail(connFail));
	serial_device_model u_serial_device_model (.core_clk(core_clk),
		.lineIn(serTxd), .lineOut(serRxd), .ctsOut(serCts));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		if (errCount == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic waitn(input int n);
		repeat (n) @(negedge core_clk);
	endtask : waitn
	task automatic loadCfg(input serial_bridge_pkg::cfg_type v);
		@(negedge core_clk);
		cfgIn = v;
		cfgLoad = 1'b1;
		@(negedge core_clk);
		cfgLoad = 1'b0;
	endtask : loadCfg
	// send one byte, return frame length in whole bit times
	task automatic sendTx(input logic [7:0] d, output int bits);
		int cnt;
		cnt = 0;
		@(negedge core_clk);
		txValid = 1'b1;
		txData = d;
		while (txReady !== 1'b1 && cnt < 100) begin
			@(negedge core_clk);
			cnt++;
		end
		@(negedge core_clk);
		txValid = 1'b0;
		cnt = 0;
		while (txReady !== 1'b1 && cnt < 20000) begin
			@(negedge core_clk);
			cnt++;
		end
		bits = (cnt + BIT / 2) / BIT;
	endtask : sendTx
	task automatic getPkt(input logic [7:0] d, input logic last);
		int cnt;
		cnt = 0;
		while (pkt.valid !== 1'b1 && cnt < 20000) begin
			@(negedge core_clk);
			cnt++;
		end
		check({23'h0, pkt.valid, pkt.data}, {24'h1, d});
		check(32'(pkt.last), 32'(last));
		@(negedge core_clk);
	endtask : getPkt
	task automatic noPkt(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) begin
			@(negedge core_clk);
			if (pkt.valid !== 1'b0)
				hit = 1'b1;
		end
		check(32'(hit), 32'h0);
	endtask : noPkt
	// ==========================================
	// watchdog
	initial begin
		repeat (90000) @(posedge core_clk);
		errCount++;
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		reset = 1'b1;
		cfgIn = serial_bridge_pkg::CFG_DEFAULT;
		cfgLoad = 1'b0;
		factoryDefault = 1'b0;
		dsrIn = 1'b0;
		txValid = 1'b0;
		txData = 8'h00;
		pktReady = 1'b1;
		established = 1'b0;
		connFail = 1'b0;
		waitn(10);
		reset = 1'b0;
		waitn(4);
		check({29'h0, serTxd, rtsOut, dtrOut}, 32'h7);
		check(32'(sess), 32'h1);
		c = serial_bridge_pkg::CFG_DEFAULT;
		c.baud = serial_bridge_pkg::BAUD_115200;
		c.parity = serial_bridge_pkg::PAR_EVEN;
		c.stop2 = 1'b1;
		c.dtr = serial_bridge_pkg::DTR_SESSION;
		c.dsr = serial_bridge_pkg::DSR_ACCEPT;
		c.gapMs = 16'h0700; // above 10 ms and one character
		loadCfg(c);
		waitn(5);
		check({30'h0, sess.acceptOk, dtrOut}, 32'h0);
		dsrIn = 1'b1;
		waitn(5);
		check(32'(sess.acceptOk), 32'h1);
		sendTx(8'ha5, nb);
		check(nb, 11);
		check(32'(u_serial_device_model.heard), 32'h0a5);
		established = 1'b1;
		waitn(3);
		check(32'(dtrOut), 32'h1);
		c.dataBits8 = 1'b0;
		c.parity = serial_bridge_pkg::PAR_NONE;
		c.stop2 = 1'b0;
		loadCfg(c);
		sendTx(8'h35, nb);
		check(nb, 10);
		check(32'(u_serial_device_model.heard), 32'h1b5);
		// receive path, 8N1 with a one second inactivity limit
		c.dataBits8 = 1'b1;
		c.idleSec = 16'h0001;
		loadCfg(c);
		u_serial_device_model.sendChar(8'h41);
		u_serial_device_model.sendChar(8'h42);
		waitn(4000);
		check({30'h0, pkt.valid, sess.close}, 32'h0);
		pktReady = 1'b0;
		getPkt(8'h41, 1'b0);
		check({23'h0, pkt.valid, pkt.data}, 32'h141);
		check(32'(sess.close), 32'h1);
		pktReady = 1'b1;
		waitn(1);
		getPkt(8'h42, 1'b1);
		// disconnect with a character still buffered
		c.idleSec = 16'h0000;
		loadCfg(c);
		u_serial_device_model.sendChar(8'h43);
		established = 1'b0;
		waitn(3);
		established = 1'b1;
		noPkt(10000);
		// combined mode: serial data requests, failure flushes
		established = 1'b0;
		c.host = serial_bridge_pkg::HOST_BOTH;
		c.dsr = serial_bridge_pkg::DSR_NONE;
		loadCfg(c);
		waitn(3);
		check(32'(sess), 32'h1);
		u_serial_device_model.sendChar(8'h44);
		waitn(5);
		check(32'(sess.connect), 32'h1);
		connFail = 1'b1;
		waitn(1);
		connFail = 1'b0;
		waitn(5);
		check(32'(sess.connect), 32'h0);
		// client mode, session follows the DSR level
		c.host = serial_bridge_pkg::HOST_CLIENT;
		c.dsr = serial_bridge_pkg::DSR_OPENCLOSE;
		loadCfg(c);
		waitn(5);
		check(32'(sess), 32'h4);
		established = 1'b1;
		waitn(3);
		dsrIn = 1'b0;
		waitn(5);
		check(32'(sess), 32'h2);
		// hardware flow control: partner not ready holds the transmitter
		c.flowHw = 1'b1;
		loadCfg(c);
		u_serial_device_model.setCts(1'b0);
		waitn(4);
		check({30'h0, txReady, rtsOut}, 32'h1);
		u_serial_device_model.setCts(1'b1);
		waitn(4);
		check(32'(txReady), 32'h1);
		established = 1'b0;
		@(negedge core_clk);
		factoryDefault = 1'b1;
		@(negedge core_clk);
		factoryDefault = 1'b0;
		waitn(3);
		check({30'h0, dtrOut, rtsOut}, 32'h3);
		check(32'(sess), 32'h1);
		give_verdict();
	end
endmodule : serial_packet_port_tb_top
